// ---- src/sac_pkg.sv ----
// Package with constants, layouts and carrier types of the sprite combiner.
package sac_pkg;

   // Sprite count, line width and beam counter width.
   localparam int SAC_NUM_SPRITES = 8;
   localparam int SAC_NUM_PAIRS = 4;
   localparam int SAC_LINE_BITS = 16;
   localparam int SAC_HPOS_W = 9;
   localparam int SAC_ADDR_W = 8;

   // Register offsets inside one sprite's block of four words, the block stride and the status word offset.
   localparam logic [1:0] SAC_REG_POS = 2'h0;
   localparam logic [1:0] SAC_REG_CTL = 2'h1;
   localparam logic [1:0] SAC_REG_DATA_A = 2'h2;
   localparam logic [1:0] SAC_REG_DATA_B = 2'h3;
   localparam logic [7:0] SAC_OFF_POS = 8'h00;
   localparam logic [7:0] SAC_OFF_CTL = 8'h04;
   localparam logic [7:0] SAC_OFF_DATA_A = 8'h08;
   localparam logic [7:0] SAC_OFF_DATA_B = 8'h0c;
   localparam logic [7:0] SAC_SPRITE_STRIDE = 8'h10;
   localparam logic [7:0] SAC_OFF_STATUS = 8'h80;

   // Field positions.
   localparam int SAC_CTL_ATTACH_BIT = 7;
   localparam int SAC_CTL_HLSB_BIT = 0;
   localparam int SAC_POS_HORIZONTAL_START_POSITION_MSB = 7;

   // Reset values, colour mapping and serialiser load count.
   localparam logic [15:0] SAC_WORD_RST = 16'h0000;
   localparam logic [4:0] SAC_COLOUR_BASE = 5'h10;
   localparam logic [4:0] SAC_BITS_LOAD = 5'h10;

   // Bus answers.
   localparam logic [1:0] SAC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SAC_RESP_SLVERR = 2'h2;

   // One write into one sprite, from the processor or from the DMA side.
   typedef struct packed {
      logic wr_pos;
      logic wr_ctl;
      logic wr_data_a;
      logic wr_data_b;
      logic [1:0] be;
      logic [15:0] word;
   } sac_wr_t;

   // Stored words of one sprite.
   typedef struct packed {
      logic [15:0] pos;
      logic [15:0] ctl;
      logic [15:0] data_a;
      logic [15:0] data_b;
   } sac_regs_t;

   // What the combiner sees of one sprite.
   typedef struct packed {
      logic armed;
      logic attach;
      logic [8:0] horizontal_start_position;
      logic [1:0] pix;
   } sac_view_t;

   typedef enum logic [0:0] {
      SAC_BUS_IDLE = 1'b0,
      SAC_BUS_RESP = 1'b1
   } sac_bus_state_t;

endpackage

// ---- src/sac_sprite_channel.sv ----
// One sprite: held words, arming and the serialiser.
`timescale 1ns/1ps
`default_nettype none
module sac_sprite_channel (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Writes and beam position.
   input wire sac_pkg::sac_wr_t wr,
   input wire logic [sac_pkg::SAC_HPOS_W-1:0] hpos,
   // Stored words and pixel view.
   output sac_pkg::sac_regs_t regs,
   output sac_pkg::sac_view_t view
);
   import sac_pkg::*;

   logic [15:0] pos_ff;
   logic [15:0] ctl_ff;
   logic [15:0] data_a_ff;
   logic [15:0] data_b_ff;
   logic armed_ff;
   logic [15:0] shift_a_ff;
   logic [15:0] shift_b_ff;
   logic [4:0] count_ff;
   logic [8:0] horizontal_start_position;
   logic hit;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input sac_wr_t w);
      merge = {w.be[1] ? w.word[15:8] : old[15:8],
               w.be[0] ? w.word[7:0] : old[7:0]};
   endfunction

   // Processor and DMA writes land here alike.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_ff <= SAC_WORD_RST;
         ctl_ff <= SAC_WORD_RST;
         data_a_ff <= SAC_WORD_RST;
         data_b_ff <= SAC_WORD_RST;
      end else begin
         if (wr.wr_pos) begin
            pos_ff <= merge(pos_ff, wr);
         end
         if (wr.wr_ctl) begin
            ctl_ff <= merge(ctl_ff, wr);
         end
         if (wr.wr_data_a) begin
            data_a_ff <= merge(data_a_ff, wr);
         end
         if (wr.wr_data_b) begin
            data_b_ff <= merge(data_b_ff, wr);
         end
      end
   end

   // A control write disarms; a first data word write arms.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_ff <= 1'b0;
      end else if (wr.wr_ctl) begin
         armed_ff <= 1'b0;
      end else if (wr.wr_data_a) begin
         armed_ff <= 1'b1;
      end
   end

   assign horizontal_start_position = {pos_ff[SAC_POS_HORIZONTAL_START_POSITION_MSB:0], ctl_ff[SAC_CTL_HLSB_BIT]};
   assign hit = armed_ff && (hpos == horizontal_start_position);

   // Sixteen pixels leave MSB first, then the serialiser idles.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_a_ff <= SAC_WORD_RST;
         shift_b_ff <= SAC_WORD_RST;
         count_ff <= 5'h00;
      end else if (wr.wr_ctl) begin
         count_ff <= 5'h00;
      end else if (hit) begin
         shift_a_ff <= data_a_ff;
         shift_b_ff <= data_b_ff;
         count_ff <= SAC_BITS_LOAD;
      end else if (count_ff != 5'h00) begin
         shift_a_ff <= {shift_a_ff[14:0], 1'b0};
         shift_b_ff <= {shift_b_ff[14:0], 1'b0};
         count_ff <= count_ff - 5'h01;
      end
   end

   assign regs = '{pos: pos_ff, ctl: ctl_ff, data_a: data_a_ff,
                   data_b: data_b_ff};
   // The second data word supplies the more significant bit.
   assign view = '{armed: armed_ff,
                   attach: ctl_ff[SAC_CTL_ATTACH_BIT],
                   horizontal_start_position: horizontal_start_position,
                   pix: (count_ff != 5'h00) ?
                        {shift_b_ff[15], shift_a_ff[15]} : 2'b00};
endmodule
`default_nettype wire

// ---- src/sac_sprite_attach.sv ----
// Top: bus slave, eight sprite channels, attachment and priority combiner.
//
// Behaviour
// - Lowest-numbered opaque sprite wins where sprites overlap.
// - Only odd sprite pairs with the even sprite just below.
// - Pair is attached only while odd sprite control bit 7 is set.
// - Each of the four pairs attaches independently.
// - Attached code is four bits, odd sprite bits on top.
// - High-order data word bit is each sprite's more significant bit.
// - Attached nonzero code selects colour register sixteen plus code.
// - Attached code zero is transparent, never register sixteen.
// - Misaligned attached pair: even sprite uses registers 17 to 19.
// - Misaligned attached pair: odd sprite uses registers 20, 24, 28.
// - Unattached sprite gives two bits, three colours plus transparent.
// - Processor loads accepted whenever a sprite is not fed by DMA.
// - Second data word written first; first data word write arms.
// - Armed sprite outputs held words each line at its start position.
// - Control write disarms; nothing shows until first data written again.
// - Position write moves the sprite any time without disarming.
// - Unattached pairs use colour groups 17, 21, 25, 29 upward.
// - Serialiser shifts sixteen bits MSB first, one per pixel, then stops.
`timescale 1ns/1ps
`default_nettype none
module sac_sprite_attach (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address channel.
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [sac_pkg::SAC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data channel.
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response channel.
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address channel.
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [sac_pkg::SAC_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data channel.
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Sprite DMA side.
   input wire logic [sac_pkg::SAC_NUM_SPRITES-1:0] dma_owned,
   input wire logic dma_wr_valid,
   input wire logic [2:0] dma_sprite,
   input wire logic [1:0] dma_reg,
   input wire logic [15:0] dma_word,
   // Beam position.
   input wire logic [sac_pkg::SAC_HPOS_W-1:0] hpos,
   // Sprite video towards the priority logic.
   output logic [4:0] pix_colour,
   output logic pix_opaque
);
   import sac_pkg::*;

   // Write side of the bus.
   sac_bus_state_t wr_state_ff;
   sac_bus_state_t nxt_wr_state;
   logic aw_held_ff;
   logic nxt_aw_held;
   logic w_held_ff;
   logic nxt_w_held;
   logic [SAC_ADDR_W-1:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic awready_ff;
   logic wready_ff;
   logic [1:0] bresp_ff;
   logic do_write;
   logic wr_mapped;
   logic wr_status;
   logic [2:0] wr_spr;
   logic [1:0] wr_reg;

   // Read side of the bus.
   sac_bus_state_t rd_state_ff;
   sac_bus_state_t nxt_rd_state;
   logic arready_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] nxt_rresp;

   // Sprite channels and combiner.
   sac_wr_t spr_wr [SAC_NUM_SPRITES];
   sac_regs_t spr_regs [SAC_NUM_SPRITES];
   sac_view_t spr_view [SAC_NUM_SPRITES];
   logic [SAC_NUM_SPRITES-1:0] armed_vec;
   logic [4:0] colour_ff;
   logic opaque_ff;
   logic [4:0] nxt_colour;
   logic nxt_opaque;

   assign wr_spr = aw_addr_ff[6:4];
   assign wr_reg = aw_addr_ff[3:2];
   assign wr_mapped = (aw_addr_ff[7] == 1'b0) && (aw_addr_ff[1:0] == 2'b00);
   assign wr_status = (aw_addr_ff == SAC_OFF_STATUS);
   assign do_write = aw_held_ff && w_held_ff &&
                     (wr_state_ff == SAC_BUS_IDLE);

   // Address and data are caught independently, in either order.
   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_w_held = w_held_ff;
      nxt_wr_state = wr_state_ff;
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_held = 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_held = 1'b1;
      end
      if (do_write) begin
         nxt_aw_held = 1'b0;
         nxt_w_held = 1'b0;
         nxt_wr_state = SAC_BUS_RESP;
      end else if (wr_state_ff == SAC_BUS_RESP && s_axi_bready) begin
         nxt_wr_state = SAC_BUS_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_ff <= SAC_BUS_IDLE;
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
      end else begin
         wr_state_ff <= nxt_wr_state;
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         awready_ff <= !nxt_aw_held && (nxt_wr_state == SAC_BUS_IDLE);
         wready_ff <= !nxt_w_held && (nxt_wr_state == SAC_BUS_IDLE);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_ff <= '0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_ff) begin
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
      end
   end

   // The status word is read only; a write to it is accepted and dropped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_ff <= SAC_RESP_OKAY;
      end else if (do_write) begin
         bresp_ff <= (wr_mapped || wr_status) ? SAC_RESP_OKAY :
                     SAC_RESP_SLVERR;
      end
   end

   // DMA writes take precedence; a processor write to a sprite the DMA
   // owns is dropped, except a position write.
   always_comb begin
      for (int i = 0; i < SAC_NUM_SPRITES; i++) begin
         spr_wr[i] = '0;
         if (dma_wr_valid && dma_sprite == i[2:0]) begin
            spr_wr[i].wr_pos = (dma_reg == SAC_REG_POS);
            spr_wr[i].wr_ctl = (dma_reg == SAC_REG_CTL);
            spr_wr[i].wr_data_a = (dma_reg == SAC_REG_DATA_A);
            spr_wr[i].wr_data_b = (dma_reg == SAC_REG_DATA_B);
            spr_wr[i].be = 2'b11;
            spr_wr[i].word = dma_word;
         end else if (do_write && wr_mapped && wr_spr == i[2:0] &&
                      (!dma_owned[i] || wr_reg == SAC_REG_POS)) begin
            spr_wr[i].wr_pos = (wr_reg == SAC_REG_POS);
            spr_wr[i].wr_ctl = (wr_reg == SAC_REG_CTL);
            spr_wr[i].wr_data_a = (wr_reg == SAC_REG_DATA_A);
            spr_wr[i].wr_data_b = (wr_reg == SAC_REG_DATA_B);
            spr_wr[i].be = w_strb_ff[1:0];
            spr_wr[i].word = w_data_ff[15:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < SAC_NUM_SPRITES; g++) begin : gen_spr
         sac_sprite_channel u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .wr(spr_wr[g]),
            .hpos(hpos),
            .regs(spr_regs[g]),
            .view(spr_view[g])
         );
         assign armed_vec[g] = spr_view[g].armed;
      end
   endgenerate

   // Read decode: the armed status word, then sprite words.
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = SAC_RESP_OKAY;
      if (s_axi_araddr == SAC_OFF_STATUS) begin
         nxt_rdata = {16'h0000, dma_owned, armed_vec};
      end else if (s_axi_araddr[7] == 1'b0 &&
                   s_axi_araddr[1:0] == 2'b00) begin
         case (s_axi_araddr[3:2])
            SAC_REG_POS: nxt_rdata[15:0] = spr_regs[s_axi_araddr[6:4]].pos;
            SAC_REG_CTL: nxt_rdata[15:0] = spr_regs[s_axi_araddr[6:4]].ctl;
            SAC_REG_DATA_A: begin
               nxt_rdata[15:0] = spr_regs[s_axi_araddr[6:4]].data_a;
            end
            SAC_REG_DATA_B: begin
               nxt_rdata[15:0] = spr_regs[s_axi_araddr[6:4]].data_b;
            end
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end else begin
         nxt_rresp = SAC_RESP_SLVERR;
      end
   end

   always_comb begin
      nxt_rd_state = rd_state_ff;
      case (rd_state_ff)
         SAC_BUS_IDLE: begin
            if (s_axi_arvalid && arready_ff) begin
               nxt_rd_state = SAC_BUS_RESP;
            end
         end
         SAC_BUS_RESP: begin
            if (s_axi_rready) begin
               nxt_rd_state = SAC_BUS_IDLE;
            end
         end
         default: nxt_rd_state = SAC_BUS_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_ff <= SAC_BUS_IDLE;
         arready_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= SAC_RESP_OKAY;
      end else begin
         rd_state_ff <= nxt_rd_state;
         arready_ff <= (nxt_rd_state == SAC_BUS_IDLE) &&
                       !(s_axi_arvalid && arready_ff);
         if (s_axi_arvalid && arready_ff) begin
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
         end
      end
   end

   // Combiner. Sprites are walked from highest to lowest number so the
   // lowest-numbered opaque one is the last to overwrite the result.
   always_comb begin
      logic [3:0] code;
      logic attached;
      logic coinc;
      logic [4:0] cand;
      int e;
      int o;
      code = 4'h0;
      attached = 1'b0;
      coinc = 1'b0;
      cand = 5'h00;
      e = 0;
      o = 0;
      nxt_colour = 5'h00;
      nxt_opaque = 1'b0;
      for (int p = SAC_NUM_PAIRS - 1; p >= 0; p--) begin
         e = 2 * p;
         o = 2 * p + 1;
         attached = spr_view[o].attach;
         coinc = attached && spr_view[e].armed && spr_view[o].armed &&
                 spr_view[e].horizontal_start_position == spr_view[o].horizontal_start_position;
         if (coinc) begin
            code = {spr_view[o].pix, spr_view[e].pix};
            if (code != 4'h0) begin
               nxt_colour = SAC_COLOUR_BASE + {1'b0, code};
               nxt_opaque = 1'b1;
            end
         end else begin
            if (spr_view[o].pix != 2'b00) begin
               if (attached) begin
                  cand = SAC_COLOUR_BASE +
                         {1'b0, spr_view[o].pix, 2'b00};
               end else begin
                  cand = SAC_COLOUR_BASE +
                         {1'b0, p[1:0], spr_view[o].pix};
               end
               nxt_colour = cand;
               nxt_opaque = 1'b1;
            end
            if (spr_view[e].pix != 2'b00) begin
               if (attached) begin
                  cand = SAC_COLOUR_BASE +
                         {3'b000, spr_view[e].pix};
               end else begin
                  cand = SAC_COLOUR_BASE +
                         {1'b0, p[1:0], spr_view[e].pix};
               end
               nxt_colour = cand;
               nxt_opaque = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         colour_ff <= 5'h00;
         opaque_ff <= 1'b0;
      end else begin
         colour_ff <= nxt_colour;
         opaque_ff <= nxt_opaque;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = (wr_state_ff == SAC_BUS_RESP);
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = (rd_state_ff == SAC_BUS_RESP);
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign pix_colour = colour_ff;
   assign pix_opaque = opaque_ff;
endmodule
`default_nettype wire

// ---- verification/sac_sprite_attach_assertions.sv ----
// Port checker of the sprite combiner, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module sac_sprite_attach_assertions (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [sac_pkg::SAC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [sac_pkg::SAC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   // DMA and video.
   input wire logic dma_wr_valid,
   input wire logic [4:0] pix_colour,
   input wire logic pix_opaque
);
   import sac_pkg::*;
   logic seen_ff;
   logic [7:0] aw_ff;
   logic [7:0] ar_ff;
   // No write of any kind yet means nothing can be armed.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         seen_ff <= 1'b0;
      else if ((s_axi_awvalid && s_axi_awready) || dma_wr_valid)
         seen_ff <= 1'b1;
   end
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready)
         aw_ff <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready)
         ar_ff <= s_axi_araddr;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reset_quiet_a: assert property ($rose(aresetn) |->
      !pix_opaque && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active just after reset");
   idle_dark_a: assert property (!seen_ff |-> !pix_opaque)
      else $error("sprite pixel before any write");
   opaque_range_a: assert property (pix_opaque |->
      pix_colour[4] && pix_colour[3:0] != 4'h0)
      else $error("opaque pixel outside colours 17 to 31");
   clear_colour_a: assert property (!pix_opaque |-> pix_colour == 5'h00)
      else $error("transparent pixel carries a colour");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   read_resp_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] ==
      16'h0000 && s_axi_rresp == (ar_ff > 8'h80 ? SAC_RESP_SLVERR :
      SAC_RESP_OKAY)) else $error("read response wrong");
   write_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp ==
      (aw_ff > 8'h80 ? SAC_RESP_SLVERR : SAC_RESP_OKAY))
      else $error("write response wrong");
   write_refuse_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   resp_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write response repeated");
   cover property (pix_opaque && pix_colour == 5'h1f);
   cover property (s_axi_bvalid && s_axi_bresp == SAC_RESP_SLVERR);
   cover property (dma_wr_valid ##[1:600] pix_opaque);
endmodule
bind sac_sprite_attach sac_sprite_attach_assertions u_sac_chk (.*);
`default_nettype wire

// ---- verification/sac_dma_model.sv ----
// Behavioural sprite DMA channel that writes one word after a delay.
`timescale 1ns/1ps
`default_nettype none
module sac_dma_model (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Requests.
   input wire logic cmd_go,
   input wire logic [2:0] cmd_sprite,
   input wire logic [1:0] cmd_reg,
   input wire logic [15:0] cmd_word,
   input wire logic [3:0] cmd_wait,
   output logic cmd_busy,
   // Writes into the sprites.
   output logic dma_wr_valid,
   output logic [2:0] dma_sprite,
   output logic [1:0] dma_reg,
   output logic [15:0] dma_word
);
   logic [3:0] cnt_ff;
   always_ff @(posedge aclk) begin
      dma_wr_valid <= 1'b0;
      // A stale word would hide a design that samples outside the pulse.
      if (dma_wr_valid)
         dma_word <= ~dma_word;
      if (!aresetn) begin
         cmd_busy <= 1'b0;
         dma_word <= 16'h0000;
         dma_sprite <= 3'h0;
         dma_reg <= 2'h0;
      end else if (cmd_go && !cmd_busy) begin
         cmd_busy <= 1'b1;
         cnt_ff <= cmd_wait;
         dma_sprite <= cmd_sprite;
         dma_reg <= cmd_reg;
         dma_word <= cmd_word;
      end else if (cmd_busy && cnt_ff == 4'h0) begin
         dma_wr_valid <= 1'b1;
         cmd_busy <= 1'b0;
      end else if (cmd_busy)
         cnt_ff <= cnt_ff - 4'h1;
   end
endmodule
`default_nettype wire

// ---- verification/test_sac_sprite_attach.sv ----
// Bench of the sprite combiner with bus tasks and a DMA partner.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
   tests_run++; \
   if ((got) !== (ex)) begin \
      mismatches++; \
      $display("MISMATCH %s exp %h got %h", nm, ex, got); \
   end \
end
module test_sac_sprite_attach;
   import sac_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, pix_opaque;
   logic dma_wr_valid, cmd_go, cmd_busy;
   logic [7:0] s_axi_awaddr, s_axi_araddr, dma_owned;
   logic [2:0] s_axi_awprot, s_axi_arprot, dma_sprite, cmd_sprite;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, cmd_wait;
   logic [1:0] s_axi_bresp, s_axi_rresp, dma_reg, cmd_reg, r;
   logic [15:0] dma_word, cmd_word;
   logic [8:0] hpos;
   logic [4:0] pix_colour;
   logic [4:0] exp_line [16];
   int mismatches, tests_run;
   sac_sprite_attach dut (.*);
   sac_dma_model u_dma (.*);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) hpos <= hpos + 9'h001;
   task automatic close_out();
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic arm(input int s, input logic [8:0] h, input logic att,
         input logic [15:0] a, input logic [15:0] b);
      logic [7:0] base;
      base = SAC_SPRITE_STRIDE * 8'(s);
      wr(base + SAC_OFF_CTL, {8'h00, att, 6'h00, h[0]});
      wr(base + SAC_OFF_POS, {8'h00, h[8:1]});
      wr(base + SAC_OFF_DATA_B, b);
      wr(base + SAC_OFF_DATA_A, a);
   endtask
   task automatic off(input int s);
      wr(SAC_SPRITE_STRIDE * 8'(s) + SAC_OFF_CTL, 16'h0000);
   endtask
   task automatic fill(input logic [15:0] a, input logic [15:0] b,
         input logic [4:0] base, input logic [4:0] step);
      logic [1:0] c;
      for (int i = 0; i < 16; i++) begin
         c = {b[15-i], a[15-i]};
         exp_line[i] = (c == 2'h0) ? 5'h00 : 5'(base + step * c);
      end
   endtask
   // Pixels leave the output flop one cycle after the start match.
   task automatic chk_line(input logic [8:0] h);
      @(posedge aclk iff hpos == h);
      @(posedge aclk);
      for (int i = 0; i < 16; i++) begin
         #1;
         `CHK("pix_colour", exp_line[i], pix_colour)
         `CHK("pix_opaque", exp_line[i] != 5'h00, pix_opaque)
         @(posedge aclk);
      end
   endtask
   task automatic dma(input logic [1:0] g, input logic [15:0] v,
         input logic [3:0] w);
      @(posedge aclk);
      cmd_reg <= g;
      cmd_word <= v;
      cmd_wait <= w;
      cmd_go <= 1'b1;
      @(posedge aclk);
      cmd_go <= 1'b0;
      @(posedge aclk);
      while (cmd_busy) @(posedge aclk);
   endtask
   task automatic t_reset();
      rd(SAC_OFF_STATUS);
      `CHK("status", 32'h00000000, d)
      rd(SAC_OFF_CTL);
      `CHK("ctl", 32'h00000000, d)
      fill(16'h0000, 16'h0000, 5'h00, 5'h00);
      chk_line(9'h1f0);
   endtask
   task automatic t_single();
      logic [8:0] h;
      for (int s = 0; s < 8; s++) begin
         h = 9'(9'h040 + s * 9);
         arm(s, h, s % 2 == 0, 16'haaaa, 16'hcccc);
         rd(SAC_OFF_STATUS);
         `CHK("armed", 32'(1 << s), d)
         fill(16'haaaa, 16'hcccc, 5'(16 + 4 * (s / 2)), 5'h01);
         chk_line(h);
         chk_line(h);
         off(s);
         wr(SAC_SPRITE_STRIDE * 8'(s) + SAC_OFF_DATA_B, 16'hffff);
         fill(16'h0000, 16'h0000, 5'h00, 5'h00);
         chk_line(h);
      end
   endtask
   task automatic t_prio();
      arm(2, 9'h050, 1'b0, 16'hff00, 16'hf0f0);
      arm(5, 9'h050, 1'b0, 16'hffff, 16'h0000);
      fill(16'hff00, 16'hf0f0, 5'h14, 5'h01);
      for (int i = 12; i < 16; i++) exp_line[i] = 5'h19;
      chk_line(9'h050);
      off(2);
      off(5);
   endtask
   task automatic t_attach();
      arm(0, 9'h020, 1'b0, 16'h5555, 16'h3333);
      arm(1, 9'h020, 1'b1, 16'h0f0f, 16'h00ff);
      arm(3, 9'h070, 1'b0, 16'haaaa, 16'hcccc);
      arm(6, 9'h0c0, 1'b0, 16'haaaa, 16'hcccc);
      arm(7, 9'h111, 1'b1, 16'haaaa, 16'hcccc);
      for (int i = 0; i < 16; i++) exp_line[i] = (i == 0) ? 5'h00 : 5'(16 + i);
      chk_line(9'h020);
      fill(16'haaaa, 16'hcccc, 5'h14, 5'h01);
      chk_line(9'h070);
      fill(16'haaaa, 16'hcccc, 5'h10, 5'h01);
      chk_line(9'h0c0);
      fill(16'haaaa, 16'hcccc, 5'h10, 5'h04);
      chk_line(9'h111);
      rd(8'h14);
      `CHK("attach", 32'h00000080, d)
      for (int s = 0; s < 8; s++) off(s);
   endtask
   task automatic t_dma();
      dma_owned <= 8'h10;
      dma(SAC_REG_CTL, 16'h0000, 4'h0);
      dma(SAC_REG_POS, 16'h0040, 4'h5);
      dma(SAC_REG_DATA_B, 16'hcccc, 4'h0);
      dma(SAC_REG_DATA_A, 16'haaaa, 4'h9);
      fill(16'haaaa, 16'hcccc, 5'h18, 5'h01);
      chk_line(9'h080);
      wr(8'h48, 16'h0000);
      wr(8'h44, 16'h0000);
      wr(8'h40, 16'h0050);
      chk_line(9'h0a0);
      dma_owned <= 8'h00;
      wr(8'h48, 16'hffff);
      fill(16'hffff, 16'hcccc, 5'h18, 5'h01);
      chk_line(9'h0a0);
      off(4);
   endtask
   task automatic t_bus();
      wr(8'h84, 16'h1234);
      `CHK("bresp", SAC_RESP_SLVERR, r)
      rd(8'hfc);
      `CHK("rresp", SAC_RESP_SLVERR, r)
      wr(SAC_OFF_STATUS, 16'hffff);
      `CHK("bresp", SAC_RESP_OKAY, r)
      rd(SAC_OFF_STATUS);
      `CHK("status", 32'h00000000, d)
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, cmd_go} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, dma_owned, hpos} = 33'h0;
      {s_axi_awprot, s_axi_arprot, cmd_sprite, cmd_reg} = 11'h010;
      {s_axi_wdata, cmd_word, cmd_wait} = 52'h0;
      s_axi_wstrb = 4'h3;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_single();
      t_prio();
      t_attach();
      t_dma();
      t_bus();
      close_out();
   end
   // Some thirty scan lines of 512 cycles fit well inside this span.
   initial begin
      #400000;
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
